//--- rtl/wpu_pkg.sv
package wpu_pkg;

	// ----------------------------------------------------------------
	// Address register layout
	// ----------------------------------------------------------------
	localparam int ADDR_HI       = 31;
	localparam int ADDR_LO       = 3;
	localparam int ADDR_W        = ADDR_HI - ADDR_LO + 1;
	localparam int EN_FETCH_BIT  = 2;
	localparam int EN_LOAD_BIT   = 1;
	localparam int EN_STORE_BIT  = 0;

	// ----------------------------------------------------------------
	// Qualifier register layout
	// ----------------------------------------------------------------
	localparam int QUAL_MORE_BIT   = 31;
	localparam int QUAL_GLOBAL_BIT = 30;
	localparam int TAG_HI          = 23;
	localparam int TAG_LO          = 16;
	localparam int TAG_W           = TAG_HI - TAG_LO + 1;
	localparam int MASK_HI         = 11;
	localparam int MASK_LO         = 3;
	localparam int MASK_W          = MASK_HI - MASK_LO + 1;
	localparam int HIT_FETCH_BIT   = 2;
	localparam int HIT_LOAD_BIT    = 1;
	localparam int HIT_STORE_BIT   = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]        ENABLE_RST = 3'h0;
	localparam logic [2:0]        HIT_RST    = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST   = 29'h0;
	localparam logic [TAG_W-1:0]  TAG_RST    = 8'h0;
	localparam logic [MASK_W-1:0] MASK_RST   = 9'h0;
	localparam logic [31:0]       WORD_ZERO  = 32'h0;

	// Doubleword compare; ones in mask drop address bits 11..3
	function automatic logic wpu_addr_match(
		input logic [31:0]       va,
		input logic [ADDR_W-1:0] watch,
		input logic [MASK_W-1:0] mask
	);
		logic [ADDR_W-1:0] care;
		care = ~{{(ADDR_W-MASK_W){1'b0}}, mask};
		return ((va[ADDR_HI:ADDR_LO] ^ watch) & care) == {ADDR_W{1'b0}};
	endfunction

endpackage

//--- rtl/wpu_access_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wpu_access_if;
	logic        clk;
	logic        rst_n;
	logic        fetch_issued;
	logic [31:0] fetch_addr;
	logic        load_valid;
	logic [31:0] load_addr;
	logic        store_valid;
	logic [31:0] store_addr;
	logic [7:0]  space_tag;

	modport src  (output clk, rst_n, fetch_issued, fetch_addr, load_valid, load_addr,
		store_valid, store_addr, space_tag);
	modport pair (input clk, rst_n, fetch_issued, fetch_addr, load_valid, load_addr,
		store_valid, store_addr, space_tag);
endinterface
`default_nettype wire

//--- rtl/wpu_pair_match.sv
`timescale 1ns/1ps
`default_nettype none
module wpu_pair_match
	import wpu_pkg::*;
(
	wpu_access_if.pair             acc,        // Pipeline accesses
	input  wire logic [ADDR_W-1:0] watch_addr, // Programmed doubleword address
	input  wire logic [2:0]        enables,    // Fetch, load, store enables
	input  wire logic              global_en,  // Ignore space tag
	input  wire logic [TAG_W-1:0]  tag,        // Space tag to match
	input  wire logic [MASK_W-1:0] mask,       // Address bits to ignore
	output logic      [2:0]        hit         // Per-condition match
);
	logic tag_ok;

	assign tag_ok = global_en || (tag == acc.space_tag); // [R3] [R4]

	// Speculative fetches never reach here: only issued ones are flagged
	assign hit[HIT_FETCH_BIT] = acc.fetch_issued && enables[EN_FETCH_BIT] && tag_ok
		&& wpu_addr_match(acc.fetch_addr, watch_addr, mask); // [R16] [R15] [R5]
	assign hit[HIT_LOAD_BIT]  = acc.load_valid && enables[EN_LOAD_BIT] && tag_ok
		&& wpu_addr_match(acc.load_addr, watch_addr, mask); // [R15] [R5] [R14]
	assign hit[HIT_STORE_BIT] = acc.store_valid && enables[EN_STORE_BIT] && tag_ok
		&& wpu_addr_match(acc.store_addr, watch_addr, mask); // [R15] [R5]

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_global_load;
		@(posedge acc.clk) disable iff (!acc.rst_n)
		(acc.load_valid && enables[EN_LOAD_BIT] && global_en
			&& ((acc.load_addr[ADDR_HI:ADDR_LO] ^ watch_addr) == '0)) |-> hit[HIT_LOAD_BIT];
	endproperty
	a_global_load: assert property (p_global_load) else $error("global load miss"); // [R3]

	property p_tag_block;
		@(posedge acc.clk) disable iff (!acc.rst_n)
		(!global_en && tag != acc.space_tag) |-> hit == 3'h0;
	endproperty
	a_tag_block: assert property (p_tag_block) else $error("hit with wrong tag"); // [R4]
endmodule
`default_nettype wire

//--- rtl/wpu_watch_unit.sv
// Notes on behaviour
// [R1] - Exception only when both level flags are zero; else set pending and defer.
// [R2] - More-pairs bit at select n says pair n+1 exists.
// [R3] - Global bit set: any address match triggers, tag ignored.
// [R4] - Global bit clear: stored tag must equal current space tag.
// [R5] - Mask ones in bits 11..3 drop those address bits from compare.
// [R6] - Unimplemented mask bits ignore writes and read zero.
// [R7] - Fetch, load, store hit flags mark the pair and the condition.
// [R8] - Hit flags stay set until a one is written; zero leaves them.
// [R9] - Writing back the read value clears only flags that were set.
// [R10] - Qualifier bits 29..24 and 15..12 read zero; writes are dropped.
// [R11] - Capability output reports at least one pair exists.
// [R12] - Pair count parameter, chosen by select; pairs may serve one kind.
// [R13] - More bit is fixed read-only; global, tag, mask are read-write.
// [R14] - Address held in bits 31..3, doubleword granularity; low bits enables.
// [R15] - Separate fetch, load, store enables gate each condition.
// [R16] - Only issued fetches trigger; speculative fetches never do.
// [R17] - Unsupported enables ignore writes and read zero.
// [R18] - Multi-pair match sets every pair's flag, one exception raised.
`timescale 1ns/1ps
`default_nettype none
module wpu_watch_unit
	import wpu_pkg::*;
#(
	parameter int                      NPAIRS    = 2,
	parameter logic [NPAIRS*3-1:0]     PAIR_KIND = {NPAIRS{3'h7}},
	parameter logic [MASK_W-1:0]       MASK_IMPL = 9'h1FF
)
(
	input  wire logic        clk,                  // Core clock
	input  wire logic        rst_n,                // Async reset, active low
	input  wire logic        coproc_move_to,       // Register write strobe
	input  wire logic        coproc_move_from,     // Register read strobe
	input  wire logic        sel_qualifier,        // 1 qualifier, 0 address reg
	input  wire logic [2:0]  sel,                  // Pair select
	input  wire logic [31:0] wdata,                // Write data
	output logic      [31:0] rdata,                // Read data, next cycle
	input  wire logic        fetch_issued,         // Issued instruction fetch
	input  wire logic [31:0] fetch_addr,           // Fetch virtual address
	input  wire logic        load_valid,           // Load access
	input  wire logic [31:0] load_addr,            // Load virtual address
	input  wire logic        store_valid,          // Store access
	input  wire logic [31:0] store_addr,           // Store virtual address
	input  wire logic [7:0]  space_tag,            // Tag from current_space_reg
	input  wire logic        exception_level_flag, // Exception level active
	input  wire logic        error_level_flag,     // Error level active
	output logic             watch_exc,            // Watch exception, one cycle
	output logic             watch_pending,        // Deferred exception held
	output logic             watch_present         // Capability bit for first_capability_reg
);
	logic [ADDR_W-1:0] addr_reg [0:NPAIRS-1];
	logic [2:0]        en_reg   [0:NPAIRS-1];
	logic              glob_reg [0:NPAIRS-1];
	logic [TAG_W-1:0]  tag_reg  [0:NPAIRS-1];
	logic [MASK_W-1:0] mask_reg [0:NPAIRS-1];
	logic [2:0]        hit_reg  [0:NPAIRS-1];
	logic [NPAIRS-1:0][2:0] pair_hit;
	logic              sel_ok;
	logic              wr_addr;
	logic              wr_qual;
	logic              any_hit;
	logic              levels_clear;
	logic [31:0]       rd_word;
	logic [31:0]       rdata_reg;
	logic              exc_reg;
	logic              pending_reg;

	wpu_access_if acc ();

	assign acc.clk          = clk;
	assign acc.rst_n        = rst_n;
	assign acc.fetch_issued = fetch_issued;
	assign acc.fetch_addr   = fetch_addr;
	assign acc.load_valid   = load_valid;
	assign acc.load_addr    = load_addr;
	assign acc.store_valid  = store_valid;
	assign acc.store_addr   = store_addr;
	assign acc.space_tag    = space_tag;

	assign sel_ok        = int'(sel) < NPAIRS; // [R12]
	assign wr_addr       = coproc_move_to && sel_ok && !sel_qualifier;
	assign wr_qual       = coproc_move_to && sel_ok && sel_qualifier;
	assign watch_present = NPAIRS > 0; // [R11]

	// ----------------------------------------------------------------
	// Pair registers and comparators
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NPAIRS; gi++)
		begin : g_pair
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					addr_reg[gi] <= ADDR_RST;
					en_reg[gi]   <= ENABLE_RST;
				end
				else if (wr_addr && int'(sel) == gi)
				begin
					addr_reg[gi] <= wdata[ADDR_HI:ADDR_LO]; // [R14]
					en_reg[gi]   <= wdata[2:0] & PAIR_KIND[gi*3 +: 3]; // [R17] [R12]
				end
			end

			// Reset leaves these at zero although software must not rely on it
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					glob_reg[gi] <= 1'b0;
					tag_reg[gi]  <= TAG_RST;
					mask_reg[gi] <= MASK_RST;
				end
				else if (wr_qual && int'(sel) == gi)
				begin
					glob_reg[gi] <= wdata[QUAL_GLOBAL_BIT]; // [R13]
					tag_reg[gi]  <= wdata[TAG_HI:TAG_LO];
					mask_reg[gi] <= wdata[MASK_HI:MASK_LO] & MASK_IMPL; // [R6]
				end
			end

			// A new hit in the clearing cycle survives the clear
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					hit_reg[gi] <= HIT_RST;
				else if (wr_qual && int'(sel) == gi)
					hit_reg[gi] <= pair_hit[gi] | (hit_reg[gi] & ~wdata[2:0]); // [R8] [R9]
				else
					hit_reg[gi] <= pair_hit[gi] | hit_reg[gi]; // [R7] [R18]
			end

			wpu_pair_match u_match (
				.acc        (acc),
				.watch_addr (addr_reg[gi]),
				.enables    (en_reg[gi]),
				.global_en  (glob_reg[gi]),
				.tag        (tag_reg[gi]),
				.mask       (mask_reg[gi]),
				.hit        (pair_hit[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Exception and deferral
	// ----------------------------------------------------------------
	assign any_hit      = |pair_hit; // [R18]
	assign levels_clear = !exception_level_flag && !error_level_flag;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			exc_reg <= 1'b0;
		else
			exc_reg <= (any_hit || pending_reg) && levels_clear; // [R1]
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pending_reg <= 1'b0;
		else if (levels_clear)
			pending_reg <= 1'b0;
		else if (any_hit)
			pending_reg <= 1'b1; // [R1]
	end

	assign watch_exc     = exc_reg;
	assign watch_pending = pending_reg;

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_word = WORD_ZERO;
		for (int i = 0; i < NPAIRS; i++)
		begin
			if (int'(sel) == i && sel_qualifier)
			begin
				rd_word[QUAL_MORE_BIT]    = i < NPAIRS - 1; // [R2] [R13]
				rd_word[QUAL_GLOBAL_BIT]  = glob_reg[i];
				rd_word[TAG_HI:TAG_LO]    = tag_reg[i];
				rd_word[MASK_HI:MASK_LO]  = mask_reg[i]; // [R10]
				rd_word[2:0]              = hit_reg[i];
			end
			else if (int'(sel) == i)
			begin
				rd_word[ADDR_HI:ADDR_LO] = addr_reg[i];
				rd_word[2:0]             = en_reg[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= WORD_ZERO;
		else if (coproc_move_from)
			rdata_reg <= rd_word;
	end

	assign rdata = rdata_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_hit_blocked;
		any_hit && !levels_clear;
	endsequence

	sequence s_release;
		pending_reg && levels_clear;
	endsequence

	property p_exc_gated;
		@(posedge clk) disable iff (!rst_n)
		watch_exc |-> $past(levels_clear);
	endproperty
	a_exc_gated: assert property (p_exc_gated) else $error("exception while level set"); // [R1]

	property p_defer;
		@(posedge clk) disable iff (!rst_n)
		s_hit_blocked |=> watch_pending && !watch_exc;
	endproperty
	a_defer: assert property (p_defer) else $error("blocked hit not deferred"); // [R1]

	property p_release;
		@(posedge clk) disable iff (!rst_n)
		s_release |=> watch_exc && !watch_pending;
	endproperty
	a_release: assert property (p_release) else $error("pending not released"); // [R1]

	property p_hit_sets;
		@(posedge clk) disable iff (!rst_n)
		pair_hit[0][HIT_LOAD_BIT] |=> hit_reg[0][HIT_LOAD_BIT] && (watch_exc || watch_pending);
	endproperty
	a_hit_sets: assert property (p_hit_sets) else $error("load hit not recorded"); // [R7]

	property p_w1c;
		@(posedge clk) disable iff (!rst_n)
		(wr_qual && sel == 3'h0) |=>
			((hit_reg[0] & $past(hit_reg[0]) & ~$past(pair_hit[0]))
				== ($past(hit_reg[0]) & ~$past(wdata[2:0]) & ~$past(pair_hit[0])));
	endproperty
	a_w1c: assert property (p_w1c) else $error("hit flag clear wrong"); // [R8] [R9]

	property p_sticky;
		@(posedge clk) disable iff (!rst_n)
		!wr_qual |=> (hit_reg[0] & $past(hit_reg[0])) == $past(hit_reg[0]);
	endproperty
	a_sticky: assert property (p_sticky) else $error("hit flag dropped"); // [R8]

	property p_reserved;
		@(posedge clk) disable iff (!rst_n)
		coproc_move_from && sel_qualifier |=> rdata[29:24] == 6'h0 && rdata[15:12] == 4'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // [R10]

	property p_mask_impl;
		@(posedge clk) disable iff (!rst_n)
		(mask_reg[0] & ~MASK_IMPL) == 9'h0;
	endproperty
	a_mask_impl: assert property (p_mask_impl) else $error("unimplemented mask bit set"); // [R6]

	property p_enable_kind;
		@(posedge clk) disable iff (!rst_n)
		(en_reg[NPAIRS-1] & ~PAIR_KIND[NPAIRS*3-1 -: 3]) == 3'h0;
	endproperty
	a_enable_kind: assert property (p_enable_kind) else $error("unsupported enable set"); // [R17]

	property p_more_bit;
		@(posedge clk) disable iff (!rst_n)
		coproc_move_from && sel_qualifier && sel_ok |=>
			rdata[QUAL_MORE_BIT] == (int'($past(sel)) < NPAIRS - 1);
	endproperty
	a_more_bit: assert property (p_more_bit) else $error("more-pairs bit wrong"); // [R2]
endmodule
`default_nettype wire

//--- sim/wpu_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module wpu_pipe_model
(
	input  wire logic   clk,          // Core clock
	output logic        fetch_issued, // Issued fetch
	output logic [31:0] fetch_addr,   // Fetch address
	output logic        load_valid,   // Load access
	output logic [31:0] load_addr,    // Load address
	output logic        store_valid,  // Store access
	output logic [31:0] store_addr    // Store address
);
	initial
	begin
		{fetch_issued, load_valid, store_valid} = 3'h0;
		{fetch_addr, load_addr, store_addr} = {3{32'h0}};
	end

	// Kind 0 fetch, 1 load, 2 store, 3 speculative fetch that never issues
	task automatic issue(input logic [1:0] kind, input logic [31:0] va);
		@(negedge clk);
		fetch_issued = (kind == 2'h0);
		load_valid = (kind == 2'h1);
		store_valid = (kind == 2'h2);
		{fetch_addr, load_addr, store_addr} = {3{va}};
		@(negedge clk);
		{fetch_issued, load_valid, store_valid} = 3'h0;
		// Idle buses flip so a stale address never looks like a held one
		{fetch_addr, load_addr, store_addr} = {3{~va}};
	endtask
endmodule
`default_nettype wire

//--- sim/tb_wpu_watch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_wpu_watch_unit import wpu_pkg::*;;
	typedef struct {
		logic [2:0]  p;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [1:0]  kind;
		logic [31:0] va;
		logic [7:0]  tag;
		logic        exc;
		logic [2:0]  hits;
		logic [31:0] lo_rd;
	} wpu_row_t;
	localparam logic [8:0] MASK_IMPL_TB = 9'h0FF;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        mv_to = 1'h0;
	logic        mv_from = 1'h0;
	logic        sel_q = 1'h0;
	logic [2:0]  sel = 3'h0;
	logic [31:0] wdata = 32'h0;
	logic [7:0]  space_tag = 8'h11;
	logic        lvl_exc = 1'h0;
	logic        lvl_err = 1'h0;
	logic [31:0] rdata, rd, rd2, fa, la, sa;
	logic        fv, lv, sv, watch_exc, watch_pending, watch_present;
	int          error_cnt = 0;
	int          check_count = 0;
	wpu_row_t    rows [10] = '{
		'{3'h0, 32'h00401002, 32'h7F00F007, 2'h1, 32'h00401004, 8'h11, 1'h1, 3'h2, 32'h00401002},
		'{3'h0, 32'h00401001, 32'h005A0007, 2'h2, 32'h00401000, 8'h5A, 1'h1, 3'h1, 32'h00401001},
		'{3'h0, 32'h00401001, 32'h005A0007, 2'h2, 32'h00401000, 8'h3C, 1'h0, 3'h0, 32'h00401001},
		'{3'h0, 32'h00401002, 32'h40000FFF, 2'h1, 32'h004017F8, 8'h11, 1'h1, 3'h2, 32'h00401002},
		'{3'h0, 32'h00401002, 32'h40000FFF, 2'h1, 32'h00401800, 8'h11, 1'h0, 3'h0, 32'h00401002},
		'{3'h0, 32'h00401004, 32'h40000007, 2'h0, 32'h00401007, 8'h11, 1'h1, 3'h4, 32'h00401004},
		'{3'h0, 32'h00401004, 32'h40000007, 2'h1, 32'h00401000, 8'h11, 1'h0, 3'h0, 32'h00401004},
		'{3'h0, 32'h00401004, 32'h40000007, 2'h3, 32'h00401000, 8'h11, 1'h0, 3'h0, 32'h00401004},
		'{3'h1, 32'h00401007, 32'h40000007, 2'h0, 32'h00401000, 8'h11, 1'h0, 3'h0, 32'h00401003},
		'{3'h1, 32'h00401007, 32'h40000007, 2'h1, 32'h00401000, 8'h11, 1'h1, 3'h2, 32'h00401003}};

	always #5 clk = ~clk;

	wpu_pipe_model pipe (.clk(clk), .fetch_issued(fv), .fetch_addr(fa), .load_valid(lv),
		.load_addr(la), .store_valid(sv), .store_addr(sa));

	// Pair 1 serves loads and stores only; mask bit 8 left out
	wpu_watch_unit #(.NPAIRS(2), .PAIR_KIND(6'h1F), .MASK_IMPL(MASK_IMPL_TB)) uut (
		.clk(clk), .rst_n(rst_n), .coproc_move_to(mv_to), .coproc_move_from(mv_from),
		.sel_qualifier(sel_q), .sel(sel), .wdata(wdata), .rdata(rdata), .fetch_issued(fv),
		.fetch_addr(fa), .load_valid(lv), .load_addr(la), .store_valid(sv), .store_addr(sa),
		.space_tag(space_tag), .exception_level_flag(lvl_exc), .error_level_flag(lvl_err),
		.watch_exc(watch_exc), .watch_pending(watch_pending), .watch_present(watch_present));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic reg_wr(input logic q, input logic [2:0] s, input logic [31:0] d);
		@(negedge clk);
		mv_to = 1'h1;
		sel_q = q;
		sel = s;
		wdata = d;
		@(negedge clk);
		mv_to = 1'h0;
	endtask

	task automatic reg_rd(input logic q, input logic [2:0] s, output logic [31:0] d);
		@(negedge clk);
		mv_from = 1'h1;
		sel_q = q;
		sel = s;
		@(negedge clk);
		mv_from = 1'h0;
		d = rdata;
	endtask

	function automatic logic [31:0] exp_qual(input logic [2:0] p, input logic [31:0] hi,
		input logic [2:0] hits);
		return {p == 3'h0, hi[30], 6'h00, hi[23:16], 4'h0, hi[11:3] & MASK_IMPL_TB, hits};
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		chk("rst_rdata", rdata, 32'h0);
		chk("rst_exc", {30'h0, watch_exc, watch_pending}, 32'h0);
		@(negedge clk);
		rst_n = 1'h1;
		chk("present", {31'h0, watch_present}, 32'h1);
		reg_rd(1'h1, 3'h0, rd);
		chk("qual0_rst", rd, 32'h80000000);
		reg_rd(1'h1, 3'h1, rd);
		chk("qual1_rst", rd, 32'h0);
		reg_rd(1'h1, 3'h5, rd);
		chk("no_pair", rd, 32'h0);
		for (int i = 0; i < 10; i++)
		begin
			reg_wr(1'h0, 3'h0, 32'h0);
			reg_wr(1'h0, 3'h1, 32'h0);
			reg_wr(1'h1, rows[i].p, rows[i].hi);
			reg_wr(1'h0, rows[i].p, rows[i].lo);
			space_tag = rows[i].tag;
			pipe.issue(rows[i].kind, rows[i].va);
			chk("exc", {31'h0, watch_exc}, {31'h0, rows[i].exc});
			reg_rd(1'h0, rows[i].p, rd);
			chk("addr_rd", rd, rows[i].lo_rd);
			reg_rd(1'h1, rows[i].p, rd);
			chk("qual_rd", rd, exp_qual(rows[i].p, rows[i].hi, rows[i].hits));
		end
		// Both pairs watch one load address
		for (int p = 0; p < 2; p++)
		begin
			reg_wr(1'h1, 3'(p), 32'h40000007);
			reg_wr(1'h0, 3'(p), 32'h00401002);
		end
		pipe.issue(2'h1, 32'h00401000);
		chk("exc_multi", {31'h0, watch_exc}, 32'h1);
		@(negedge clk);
		chk("exc_once", {31'h0, watch_exc}, 32'h0);
		for (int p = 0; p < 2; p++)
		begin
			reg_rd(1'h1, 3'(p), rd);
			chk("hit_multi", rd & 32'h7, 32'h2);
		end
		// Zero writes keep flags; write-back clears only what was read set
		reg_wr(1'h0, 3'h1, 32'h0);
		reg_wr(1'h0, 3'h0, 32'h00401003);
		reg_rd(1'h1, 3'h0, rd);
		reg_wr(1'h1, 3'h0, rd & 32'hFFFFFFF8);
		reg_rd(1'h1, 3'h0, rd2);
		chk("hit_kept", rd2 & 32'h7, 32'h2);
		pipe.issue(2'h2, 32'h00401000);
		reg_wr(1'h1, 3'h0, rd);
		reg_rd(1'h1, 3'h0, rd);
		chk("hit_wb", rd & 32'h7, 32'h1);
		// Deferral through both level flags
		lvl_exc = 1'h1;
		pipe.issue(2'h1, 32'h00401000);
		chk("defer", {30'h0, watch_exc, watch_pending}, 32'h1);
		lvl_exc = 1'h0;
		lvl_err = 1'h1;
		@(negedge clk);
		chk("defer_err", {30'h0, watch_exc, watch_pending}, 32'h1);
		lvl_err = 1'h0;
		@(negedge clk);
		chk("release", {30'h0, watch_exc, watch_pending}, 32'h2);
		@(negedge clk);
		chk("release_end", {30'h0, watch_exc, watch_pending}, 32'h0);
		// Reset in mid-run drops a deferred exception and every field of pair 0
		lvl_exc = 1'h1;
		pipe.issue(2'h1, 32'h00401000);
		rst_n = 1'h0;
		lvl_exc = 1'h0;
		@(negedge clk);
		chk("rst_mid", {30'h0, watch_exc, watch_pending}, 32'h0);
		rst_n = 1'h1;
		reg_rd(1'h1, 3'h0, rd);
		chk("rst_qual", rd, 32'h80000000);
		reg_rd(1'h0, 3'h0, rd);
		chk("rst_addr", rd, 32'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
